// >>> add_shift_pkg.sv
// Constants, types and register map of the add/shift execution block.
// Assumes an AHB-Lite master with single word transfers and one core clock.
// Summary of operation
// (RQ1) Taken branch or true test costs two instruction cycles, second a no-op.
// (RQ2) Indirect access with pointer top bit set adds one instruction cycle.
// (RQ3) Add-to-pointer sign-extends a 6-bit literal into pointer n; no flags.
// (RQ4) Pointer sums wrap modulo 65536.
// (RQ5) Add literal to work register; update carry, digit carry, zero.
// (RQ6) Add work to file; d selects work (0) or file (1); C, DC, Z.
// (RQ7) Add work, file and carry; destination by d; C, DC, Z.
// (RQ8) AND literal into work register; only zero flag changes.
// (RQ9) AND work with file; only zero; d selects destination.
// (RQ10) Shift right: bits 7..1 to 6..0, bit 7 kept, old bit 0 to carry.
// (RQ11) Shift updates only carry and zero; d selects destination.
// (RQ12) Add literal to work decodes from upper six bits 111110; one cycle.
// (RQ13) Add-to-pointer decodes from 1100010, n, 6-bit literal; one cycle.
// (RQ14) Zero when result is zero; carry from bit 7, digit carry from bit 3.
// (RQ15) Other instructions of the group complete in one instruction cycle.
package add_shift_pkg;
  // Byte offsets on the bus
  localparam logic [11:0] REG_INSTR = 12'h000;
  localparam logic [11:0] REG_WORK = 12'h004;
  localparam logic [11:0] REG_STATUS = 12'h008;
  localparam logic [11:0] REG_PTR0 = 12'h00c;
  localparam logic [11:0] REG_PTR1 = 12'h010;
  localparam logic [11:0] REG_LAST = 12'h014;
  localparam logic [2:0] FILE_WINDOW = 3'h1;
  // Field positions
  localparam int INSTR_PC_BIT = 16;
  localparam int INSTR_COND_BIT = 17;
  localparam int ST_C = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z = 2;
  localparam int ST_BUSY = 8;
  localparam int LAST_ILLEGAL = 8;
  localparam int OPC_D_BIT = 7;
  localparam int OPC_N_BIT = 6;
  // Reset values
  localparam logic [7:0] WORK_RST = 8'h00;
  localparam logic [15:0] PTR_RST = 16'h0000;
  localparam logic [7:0] FILE_RST = 8'h00;
  // Opcode fields
  localparam logic [5:0] OPC_ADD_LIT = 6'h3e;
  localparam logic [5:0] OPC_AND_LIT = 6'h39;
  localparam logic [5:0] OPC_ADD_FILE = 6'h07;
  localparam logic [5:0] OPC_ADD_CARRY = 6'h3d;
  localparam logic [5:0] OPC_AND_FILE = 6'h05;
  localparam logic [5:0] OPC_ASR = 6'h37;
  localparam logic [6:0] OPC_ADD_PTR = 7'h62;
  // File addresses that reach memory through a pointer
  localparam logic [6:0] INDIRECT0_ADDR = 7'h00;
  localparam logic [6:0] INDIRECT1_ADDR = 7'h01;
  // Instruction cycle counts
  localparam logic [1:0] CYC_BASE = 2'h1;
  localparam logic [1:0] CYC_EXTRA = 2'h1;

  typedef enum logic [7:0] {
    OP_NONE = 8'h01,
    OP_ADD_PTR = 8'h02,
    OP_ADD_LIT = 8'h04,
    OP_ADD_FILE = 8'h08,
    OP_ADD_CARRY = 8'h10,
    OP_AND_LIT = 8'h20,
    OP_AND_FILE = 8'h40,
    OP_ASR = 8'h80
  } op_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'h1,
    BUS_WAIT = 2'h2
  } bus_state_t;

  typedef struct packed {
    logic c;
    logic dc;
    logic z;
  } flags_t;

  typedef struct packed {
    logic [7:0] result;
    flags_t flags;
    flags_t update;
  } alu_out_t;
endpackage

// >>> add_shift_alu.sv
// Eight-bit arithmetic and logic unit for the add, AND and shift group.
// Assumes operands are stable within the cycle; purely combinational.
module add_shift_alu (
  // Operation and operands
  input wire add_shift_pkg::op_t op,
  input wire logic [7:0] work,
  input wire logic [7:0] operand,
  input wire add_shift_pkg::flags_t flags_in,
  // Result and flags
  output add_shift_pkg::alu_out_t alu_out
);
  logic [8:0] sum;
  logic [4:0] low_sum;
  logic cin;

  always_comb begin
    cin = (op == add_shift_pkg::OP_ADD_CARRY) ? flags_in.c : 1'b0;
    sum = {1'b0, work} + {1'b0, operand} + {8'h00, cin};
    low_sum = {1'b0, work[3:0]} + {1'b0, operand[3:0]} + {4'h0, cin};
    alu_out.flags = flags_in;
    alu_out.update = '0;
    alu_out.result = work;
    unique case (op)
      add_shift_pkg::OP_ADD_LIT, add_shift_pkg::OP_ADD_FILE,
      add_shift_pkg::OP_ADD_CARRY: begin
        alu_out.result = sum[7:0]; // [RQ5] [RQ6] [RQ7]
        alu_out.flags.c = sum[8]; // [RQ14]
        alu_out.flags.dc = low_sum[4]; // [RQ14]
        alu_out.update = '{c: 1'b1, dc: 1'b1, z: 1'b1};
      end
      add_shift_pkg::OP_AND_LIT, add_shift_pkg::OP_AND_FILE: begin
        alu_out.result = work & operand; // [RQ8] [RQ9]
        alu_out.update = '{c: 1'b0, dc: 1'b0, z: 1'b1};
      end
      add_shift_pkg::OP_ASR: begin
        alu_out.result = {operand[7], operand[7:1]}; // [RQ10]
        alu_out.flags.c = operand[0]; // [RQ10]
        alu_out.update = '{c: 1'b1, dc: 1'b0, z: 1'b1}; // [RQ11]
      end
      add_shift_pkg::OP_NONE, add_shift_pkg::OP_ADD_PTR: begin
        alu_out.result = work;
      end
      default: begin
        alu_out.result = work;
      end
    endcase
    alu_out.flags.z = (alu_out.result == 8'h00); // [RQ14]
  end
endmodule

// >>> add_shift_timer.sv
// Instruction cycle timer: holds busy for the cycles an instruction costs.
// Assumes load is a one-clock pulse that only comes while not busy.
module add_shift_timer #(
  parameter int CYCLE_CLKS = 1
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Start of an instruction and its instruction cycle count
  input wire logic load,
  input wire logic [1:0] cycles,
  // Core occupied
  output logic busy
);
  logic [7:0] remaining;

  // Refuse cycle lengths whose product overflows the 8-bit down counter
  if (CYCLE_CLKS < 1 || CYCLE_CLKS > 63) begin
    $error("CYCLE_CLKS must lie in 1..63");
  end

  // Each instruction cycle spans CYCLE_CLKS clocks
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      remaining <= 8'h00;
    end else if (load) begin
      remaining <= 8'(cycles * CYCLE_CLKS); // [RQ1] [RQ2] [RQ15]
    end else if (remaining != 8'h00) begin
      remaining <= remaining - 8'h01;
    end
  end

  assign busy = (remaining != 8'h00);
endmodule

// >>> add_shift_exec.sv
// Execution datapath for the add, AND and shift instruction group.
// Assumes one AHB-Lite master issuing single word transfers, OKAY only.
module add_shift_exec #(
  parameter int CYCLE_CLKS = 1
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp
);
  add_shift_pkg::bus_state_t bus_state;
  logic [11:0] addr_q;
  logic write_q;
  logic access;
  logic wr_en;
  logic start;
  logic busy;
  logic file_hit;
  logic [6:0] file_idx;

  logic [7:0] work;
  add_shift_pkg::flags_t flags;
  logic [15:0] ptr0;
  logic [15:0] ptr1;
  logic [1:0] last_cycles;
  logic last_illegal;
  logic [7:0] file_mem [128];

  // Decode
  logic [13:0] opc;
  add_shift_pkg::op_t op;
  logic dest_file;
  logic ptr_sel;
  logic [5:0] ptr_lit;
  logic [6:0] f_addr;
  logic file_op;
  logic indirect;
  logic ind_sel;
  logic [15:0] ind_ptr;
  logic [6:0] eff_addr;
  logic [7:0] operand;
  logic [7:0] fval;
  logic extra;
  logic branch;
  logic [1:0] next_cycles;
  logic [15:0] ptr_sum;
  add_shift_pkg::alu_out_t alu_out;
  logic [7:0] alu_res;
  logic [7:0] lit;
  logic fval_lsb;
  logic [31:0] next_rdata;

  // Hold the data phase while an instruction still occupies the core
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_state <= add_shift_pkg::BUS_IDLE;
      addr_q <= 12'h000;
      write_q <= 1'b0;
      hreadyout <= 1'b1;
    end else begin
      unique case (bus_state)
        add_shift_pkg::BUS_IDLE: begin
          if (hsel && htrans[1] && hready) begin
            bus_state <= add_shift_pkg::BUS_WAIT;
            addr_q <= haddr[11:0];
            write_q <= hwrite;
            hreadyout <= 1'b0;
          end
        end
        add_shift_pkg::BUS_WAIT: begin
          if (!busy) begin
            bus_state <= add_shift_pkg::BUS_IDLE;
            hreadyout <= 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  assign access = (bus_state == add_shift_pkg::BUS_WAIT) && !busy;
  assign wr_en = access && write_q;
  assign start = wr_en && (addr_q == add_shift_pkg::REG_INSTR);
  assign file_hit = (addr_q[11:9] == add_shift_pkg::FILE_WINDOW);
  assign file_idx = addr_q[8:2];

  // Instruction decode from the written word
  always_comb begin
    opc = hwdata[13:0];
    op = add_shift_pkg::OP_NONE;
    if (opc[13:7] == add_shift_pkg::OPC_ADD_PTR) begin
      op = add_shift_pkg::OP_ADD_PTR; // [RQ13]
    end else begin
      unique case (opc[13:8])
        add_shift_pkg::OPC_ADD_LIT: op = add_shift_pkg::OP_ADD_LIT; // [RQ12]
        add_shift_pkg::OPC_AND_LIT: op = add_shift_pkg::OP_AND_LIT;
        add_shift_pkg::OPC_ADD_FILE: op = add_shift_pkg::OP_ADD_FILE;
        add_shift_pkg::OPC_ADD_CARRY: op = add_shift_pkg::OP_ADD_CARRY;
        add_shift_pkg::OPC_AND_FILE: op = add_shift_pkg::OP_AND_FILE;
        add_shift_pkg::OPC_ASR: op = add_shift_pkg::OP_ASR;
        default: op = add_shift_pkg::OP_NONE;
      endcase
    end
  end

  assign dest_file = opc[add_shift_pkg::OPC_D_BIT];
  assign ptr_sel = opc[add_shift_pkg::OPC_N_BIT];
  assign ptr_lit = opc[5:0];
  assign lit = opc[7:0];
  assign f_addr = opc[6:0];
  assign file_op = (op == add_shift_pkg::OP_ADD_FILE)
    || (op == add_shift_pkg::OP_ADD_CARRY)
    || (op == add_shift_pkg::OP_AND_FILE)
    || (op == add_shift_pkg::OP_ASR);

  // Indirect location reaches file memory through its pointer
  assign indirect = file_op && ((f_addr == add_shift_pkg::INDIRECT0_ADDR)
    || (f_addr == add_shift_pkg::INDIRECT1_ADDR));
  assign ind_sel = (f_addr == add_shift_pkg::INDIRECT1_ADDR);
  assign ind_ptr = ind_sel ? ptr1 : ptr0;
  assign eff_addr = indirect ? ind_ptr[6:0] : f_addr;
  assign fval = file_mem[eff_addr];
  assign fval_lsb = fval[0];
  assign operand = file_op ? fval : lit;
  assign extra = indirect && ind_ptr[15]; // [RQ2]
  assign branch = hwdata[add_shift_pkg::INSTR_PC_BIT]
    || hwdata[add_shift_pkg::INSTR_COND_BIT];

  // Instruction cycle count: base, no-op after a branch, indirect penalty
  always_comb begin
    next_cycles = add_shift_pkg::CYC_BASE; // [RQ15]
    if (branch) begin
      next_cycles = next_cycles + add_shift_pkg::CYC_EXTRA; // [RQ1]
    end
    if (extra) begin
      next_cycles = next_cycles + add_shift_pkg::CYC_EXTRA; // [RQ2]
    end
  end

  // Sign-extended literal, 16-bit sum wraps on its own
  assign ptr_sum = (ptr_sel ? ptr1 : ptr0)
    + {{10{ptr_lit[5]}}, ptr_lit}; // [RQ3] [RQ4]

  add_shift_alu u_alu (
    .op(op),
    .work(work),
    .operand(operand),
    .flags_in(flags),
    .alu_out(alu_out)
  );

  assign alu_res = alu_out.result;

  add_shift_timer #(
    .CYCLE_CLKS(CYCLE_CLKS)
  ) u_timer (
    .hclk(hclk),
    .hresetn(hresetn),
    .load(start),
    .cycles(next_cycles),
    .busy(busy)
  );

  // Working register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      work <= add_shift_pkg::WORK_RST;
    end else if (start) begin
      if (op == add_shift_pkg::OP_ADD_LIT
          || op == add_shift_pkg::OP_AND_LIT) begin
        work <= alu_res; // [RQ5] [RQ8]
      end else if (file_op && !dest_file) begin
        work <= alu_res; // [RQ6] [RQ7] [RQ9] [RQ11]
      end
    end else if (wr_en && addr_q == add_shift_pkg::REG_WORK) begin
      work <= hwdata[7:0];
    end
  end

  // Status flags, each only where the operation updates it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags <= '0;
    end else if (start) begin
      if (alu_out.update.c) begin
        flags.c <= alu_out.flags.c; // [RQ14]
      end
      if (alu_out.update.dc) begin
        flags.dc <= alu_out.flags.dc; // [RQ14]
      end
      if (alu_out.update.z) begin
        flags.z <= alu_out.flags.z; // [RQ14]
      end
    end else if (wr_en && addr_q == add_shift_pkg::REG_STATUS) begin
      flags.c <= hwdata[add_shift_pkg::ST_C];
      flags.dc <= hwdata[add_shift_pkg::ST_DC];
      flags.z <= hwdata[add_shift_pkg::ST_Z];
    end
  end

  // Pointer pair updates
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ptr0 <= add_shift_pkg::PTR_RST;
      ptr1 <= add_shift_pkg::PTR_RST;
    end else if (start && op == add_shift_pkg::OP_ADD_PTR) begin
      if (ptr_sel) begin
        ptr1 <= ptr_sum; // [RQ3]
      end else begin
        ptr0 <= ptr_sum; // [RQ3]
      end
    end else if (wr_en && addr_q == add_shift_pkg::REG_PTR0) begin
      ptr0 <= hwdata[15:0];
    end else if (wr_en && addr_q == add_shift_pkg::REG_PTR1) begin
      ptr1 <= hwdata[15:0];
    end
  end

  // File memory: instruction result or bus write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 128; i++) begin
        file_mem[i] <= add_shift_pkg::FILE_RST;
      end
    end else if (start && file_op && dest_file) begin
      file_mem[eff_addr] <= alu_res; // [RQ6] [RQ7] [RQ9] [RQ11]
    end else if (wr_en && file_hit) begin
      file_mem[file_idx] <= hwdata[7:0];
    end
  end

  // Cost and legality of the last instruction
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last_cycles <= 2'h0;
      last_illegal <= 1'b0;
    end else if (start) begin
      last_cycles <= next_cycles;
      last_illegal <= (op == add_shift_pkg::OP_NONE);
    end
  end

  // Read data
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (file_hit) begin
      next_rdata[7:0] = file_mem[file_idx];
    end else begin
      unique case (addr_q)
        add_shift_pkg::REG_WORK: next_rdata[7:0] = work;
        add_shift_pkg::REG_STATUS: begin
          next_rdata[add_shift_pkg::ST_C] = flags.c;
          next_rdata[add_shift_pkg::ST_DC] = flags.dc;
          next_rdata[add_shift_pkg::ST_Z] = flags.z;
          next_rdata[add_shift_pkg::ST_BUSY] = busy;
        end
        add_shift_pkg::REG_PTR0: next_rdata[15:0] = ptr0;
        add_shift_pkg::REG_PTR1: next_rdata[15:0] = ptr1;
        add_shift_pkg::REG_LAST: begin
          next_rdata[1:0] = last_cycles;
          next_rdata[add_shift_pkg::LAST_ILLEGAL] = last_illegal;
        end
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (access && !write_q) begin
      hrdata <= next_rdata;
    end
  end

  // Checks
  logic [7:0] busy_run;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_run <= 8'h00;
    end else if (start) begin
      busy_run <= 8'h00;
    end else if (busy) begin
      busy_run <= busy_run + 8'h01;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  branch_two_a: assert property ( // [RQ1]
    start && branch && !extra |=> last_cycles == 2'h2)
    else $error("Branch did not cost two cycles");
  indirect_extra_a: assert property ( // [RQ2]
    start && extra |=> last_cycles == 2'h2 + 2'($past(branch)))
    else $error("Indirect penalty missing");
  single_cycle_a: assert property ( // [RQ15]
    start && !branch && !extra |=> last_cycles == 2'h1)
    else $error("Plain instruction not single cycle");
  busy_length_a: assert property ( // [RQ1]
    $fell(busy) |-> busy_run == 8'(last_cycles * CYCLE_CLKS))
    else $error("Busy length differs from cycle count");
  pointer_add_a: assert property ( // [RQ3]
    start && op == add_shift_pkg::OP_ADD_PTR |=>
      (($past(ptr_sel) ? ptr1 : ptr0)
        == 16'($past(ptr_sel ? ptr1 : ptr0)
        + {{10{$past(ptr_lit[5])}}, $past(ptr_lit)}))
      && flags == $past(flags))
    else $error("Pointer add wrong or flags moved");
  pointer_wrap_a: assert property ( // [RQ4]
    start && op == add_shift_pkg::OP_ADD_PTR && !ptr_sel
      && ptr0 == 16'hffff && ptr_lit == 6'h01 |=> ptr0 == 16'h0000)
    else $error("Pointer did not wrap");
  add_literal_a: assert property ( // [RQ5]
    start && op == add_shift_pkg::OP_ADD_LIT |=>
      work == 8'($past(work) + $past(lit)))
    else $error("Add literal result wrong");
  zero_flag_a: assert property ( // [RQ14]
    start && op != add_shift_pkg::OP_NONE
      && op != add_shift_pkg::OP_ADD_PTR |=>
      flags.z == ($past(alu_res) == 8'h00))
    else $error("Zero flag wrong");
  and_flags_a: assert property ( // [RQ8]
    start && (op == add_shift_pkg::OP_AND_LIT
      || op == add_shift_pkg::OP_AND_FILE) |=>
      flags.c == $past(flags.c) && flags.dc == $past(flags.dc))
    else $error("AND changed carry flags");
  shift_carry_a: assert property ( // [RQ10]
    start && op == add_shift_pkg::OP_ASR |=>
      flags.c == $past(fval_lsb) && flags.dc == $past(flags.dc))
    else $error("Shift carry wrong");
  file_dest_a: assert property ( // [RQ6]
    start && file_op && dest_file |=> work == $past(work))
    else $error("File destination touched work");
  bus_stall_a: assert property (
    bus_state == add_shift_pkg::BUS_WAIT && busy |=> !hreadyout)
    else $error("Answered while busy");

  cover_ptr_c: cover property (start && op == add_shift_pkg::OP_ADD_PTR);
  cover_ind_c: cover property (start && extra);
  cover_branch_c: cover property (start && branch && file_op);
endmodule

// >>> tb.sv
// Self-checking bench for the add, AND and shift execution block.
// Assumes the block is the only AHB-Lite slave: hready comes from hreadyout.
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [5:0] ADD_LIT = add_shift_pkg::OPC_ADD_LIT;
  localparam logic [5:0] AND_LIT = add_shift_pkg::OPC_AND_LIT;
  localparam logic [5:0] ADD_F = add_shift_pkg::OPC_ADD_FILE;
  localparam logic [5:0] ADD_C = add_shift_pkg::OPC_ADD_CARRY;
  localparam logic [5:0] AND_F = add_shift_pkg::OPC_AND_FILE;
  localparam logic [5:0] SHIFT = add_shift_pkg::OPC_ASR;
  localparam logic [6:0] ADD_P = add_shift_pkg::OPC_ADD_PTR;

  logic hclk;
  logic hresetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  logic [6:0] fidx;
  int fail_count;
  int checks_done;

  add_shift_exec #(.CYCLE_CLKS(3)) add_shift_exec_inst (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hreadyout),
    .hreadyout(hreadyout),
    .hrdata(hrdata),
    .hresp(hresp)
  );

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what,
               seen, exp);
    end
  endtask

  task automatic results;
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Waits for hready sampled high at a rising edge, bounded
  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 1000);
    if (n >= 1000) begin
      fail_count++;
      $display("mismatch at %0t: hready never returned", $time);
      results();
    end
  endtask

  task automatic xfer(input logic [11:0] a, input logic w,
                      input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {20'h00000, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
    check({31'h0, hresp}, 32'h0, "response");
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] unused;
    xfer(a, 1'b1, d, unused);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e,
                        input string what);
    logic [31:0] v;
    xfer(a, 1'b0, 32'h0, v);
    check(v, e, what);
  endtask

  function automatic logic [11:0] faddr(input logic [6:0] i);
    return {add_shift_pkg::FILE_WINDOW, i, 2'h0};
  endfunction

  function automatic logic [13:0] fo(input logic [5:0] o, input logic d);
    return {o, d, 7'h05};
  endfunction

  function automatic logic [13:0] lo(input logic [5:0] o,
                                     input logic [7:0] k);
    return {o, k};
  endfunction

  // Preset work/file/status from hex-packed in, check hex-packed out
  task automatic run(input logic [13:0] op, input logic [1:0] br,
                     input logic [19:0] in, input logic [23:0] out);
    wr(add_shift_pkg::REG_WORK, {24'h0, in[19:12]});
    wr(faddr(fidx), {24'h0, in[11:4]});
    wr(add_shift_pkg::REG_STATUS, {28'h0, in[3:0]});
    wr(add_shift_pkg::REG_INSTR, {14'h0, br, 2'h0, op});
    rd_chk(add_shift_pkg::REG_WORK, {24'h0, out[23:16]}, "work");
    rd_chk(faddr(fidx), {24'h0, out[15:8]}, "file");
    rd_chk(add_shift_pkg::REG_STATUS, {28'h0, out[7:4]}, "status");
    rd_chk(add_shift_pkg::REG_LAST, {28'h0, out[3:0]}, "cycles");
  endtask

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    fidx = 7'h05;
    fail_count = 0;
    checks_done = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Reset state and an unmapped place
    rd_chk(add_shift_pkg::REG_WORK, 32'h0, "work reset");
    rd_chk(add_shift_pkg::REG_STATUS, 32'h0, "status reset");
    rd_chk(add_shift_pkg::REG_PTR0, 32'h0, "ptr0 reset");
    rd_chk(add_shift_pkg::REG_LAST, 32'h0, "last reset");
    rd_chk(faddr(7'h7f), 32'h0, "file reset");
    wr(12'h100, 32'h000000ff);
    rd_chk(12'h100, 32'h0, "unmapped");
    // Add literal
    run(lo(ADD_LIT, 8'h01), 2'h0, 20'h0f000, 24'h100021);
    run(lo(ADD_LIT, 8'h01), 2'h0, 20'hff000, 24'h000071);
    run(lo(ADD_LIT, 8'h30), 2'h0, 20'h20007, 24'h500001);
    // Add work to file, plain and with carry
    run(fo(ADD_F, 1'b0), 2'h0, 20'h80800, 24'h008051);
    run(fo(ADD_F, 1'b1), 2'h0, 20'h12347, 24'h124601);
    run(fo(ADD_C, 1'b0), 2'h0, 20'h010e1, 24'h100e21);
    run(fo(ADD_C, 1'b1), 2'h0, 20'hff001, 24'hff0071);
    run(fo(ADD_C, 1'b1), 2'h0, 20'h01010, 24'h010201);
    // AND with literal and with file
    run(lo(AND_LIT, 8'h0f), 2'h0, 20'hf0003, 24'h000071);
    run(lo(AND_LIT, 8'h3c), 2'h0, 20'hf3004, 24'h300001);
    run(fo(AND_F, 1'b1), 2'h0, 20'h3ca53, 24'h3c2431);
    run(fo(AND_F, 1'b0), 2'h0, 20'h0ff00, 24'h00f041);
    // Arithmetic right shift
    run(fo(SHIFT, 1'b0), 2'h0, 20'h55812, 24'hc08131);
    run(fo(SHIFT, 1'b1), 2'h0, 20'h55021, 24'h550101);
    run(fo(SHIFT, 1'b1), 2'h0, 20'h55012, 24'h550071);
    // Program counter change and true test
    run(lo(ADD_LIT, 8'h00), 2'h1, 20'h01000, 24'h010002);
    run(lo(ADD_LIT, 8'h00), 2'h2, 20'h01000, 24'h010002);
    // Pointer additions wrap, flags untouched
    wr(add_shift_pkg::REG_PTR0, 32'h0000ffff);
    run({ADD_P, 1'b0, 6'h01}, 2'h0, 20'h00005, 24'h000051);
    rd_chk(add_shift_pkg::REG_PTR0, 32'h0, "ptr0 wrap");
    wr(add_shift_pkg::REG_PTR1, 32'h00000010);
    run({ADD_P, 1'b1, 6'h20}, 2'h0, 20'h00002, 24'h000021);
    rd_chk(add_shift_pkg::REG_PTR1, 32'h0000fff0, "ptr1 neg");
    wr(add_shift_pkg::REG_PTR1, 32'h00007ffe);
    run({ADD_P, 1'b1, 6'h1f}, 2'h0, 20'h00000, 24'h000001);
    rd_chk(add_shift_pkg::REG_PTR1, 32'h0000801d, "ptr1 pos");
    // Indirect access through a pointer with and without top bit
    fidx = 7'h03;
    wr(add_shift_pkg::REG_PTR0, 32'h00008003);
    run({ADD_F, 1'b1, 7'h00}, 2'h0, 20'h05100, 24'h051502);
    run({AND_F, 1'b0, 7'h00}, 2'h1, 20'hff0f0, 24'h0f0f03);
    wr(add_shift_pkg::REG_PTR1, 32'h00000003);
    run({ADD_F, 1'b0, 7'h01}, 2'h0, 20'h01020, 24'h030201);
    // Unknown opcode leaves state alone
    wr(add_shift_pkg::REG_INSTR, 32'h0);
    rd_chk(add_shift_pkg::REG_LAST, 32'h00000101, "unknown opcode");
    rd_chk(add_shift_pkg::REG_WORK, 32'h00000003, "work kept");
    results();
  end

  // Whole run takes several hundred clocks
  initial begin
    repeat (50000) @(posedge hclk);
    fail_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    results();
  end
endmodule
